// [rtl/dbp_consts.vh]
// Constants for the DMA bus setting and drive task file window.
// Assumes a 100 MHz mclk and a word-aligned AHB-Lite register map.
`ifndef DBP_CONSTS_VH
`define DBP_CONSTS_VH

// Register indexes; byte address is four times the index
`define DBP_IDX_DMA_CFG      8'h38
`define DBP_IDX_HW_SETUP     8'h3C
`define DBP_IDX_TF_DATA      8'h40
`define DBP_IDX_TF_CMD       8'h44
`define DBP_IDX_TF_FEAT      8'h48
`define DBP_IDX_TF_CNT       8'h49
`define DBP_IDX_TF_LBA0      8'h4A
`define DBP_IDX_TF_LBA1      8'h4B
`define DBP_IDX_TF_LBA2      8'h4C
`define DBP_IDX_TF_DRV       8'h4D
`define DBP_IDX_TF_ALT       8'h4E
`define DBP_IDX_TF_DADDR     8'h4F
`define DBP_IDX_HOST_CTL     8'h60

// Hardware setting fields
`define DBP_HW_LANE_HI       7
`define DBP_HW_LANE_LO       6
`define DBP_HW_EOT_LVL       5
`define DBP_HW_MASTER        4
`define DBP_HW_ACK_LVL       3
`define DBP_HW_REQ_LVL       2
`define DBP_HW_WR_LVL        1
`define DBP_HW_RD_LVL        0
`define DBP_LANE_NORMAL      2'h0
`define DBP_LANE_SWAP        2'h1

// Reset values
`define DBP_HW_RST           8'h04
`define DBP_CFG_RST          16'h0001
`define DBP_CFG_MASK         16'h3F8D
`define DBP_TF_RST           8'h00
`define DBP_CMD_READ         32'h000000FF

// Host control fields
`define DBP_CTL_HOST8        0
`define DBP_CTL_BUSY         8
`define DBP_CTL_BYTE_PH      9

// Drive address codes
`define DBP_DA_DATA          3'h0
`define DBP_DA_FEAT          3'h1
`define DBP_DA_CNT           3'h2
`define DBP_DA_LBA0          3'h3
`define DBP_DA_LBA1          3'h4
`define DBP_DA_LBA2          3'h5
`define DBP_DA_DRV           3'h6
`define DBP_DA_CMD           3'h7

// Programmed I/O timing
`define DBP_CLK_NS           10
`define DBP_T_SETUP_NS       70
`define DBP_T_STROBE_NS      165
`define DBP_T_RECOVER_NS     30
`define DBP_CYC(ns)          (((ns) + `DBP_CLK_NS - 1) / `DBP_CLK_NS)

`endif

// [rtl/dbp_pio.v]
// Drive-side programmed I/O cycle engine with strobe polarity.
// Assumes start is a one-cycle pulse issued only while busy is low.
`timescale 1ns/1ns
`include "dbp_consts.vh"

module dbp_pio #(
  parameter SETUP_CYC   = `DBP_CYC(`DBP_T_SETUP_NS),
  parameter STROBE_CYC  = `DBP_CYC(`DBP_T_STROBE_NS),
  parameter RECOVER_CYC = `DBP_CYC(`DBP_T_RECOVER_NS)
) (
  input  wire        mclk,
  input  wire        clr,
  input  wire        start,
  input  wire        wr,
  input  wire        ctl_blk,
  input  wire [2:0]  addr,
  input  wire [15:0] wdata,
  input  wire        rd_lvl,
  input  wire        wr_lvl,
  input  wire        ext_rd,
  input  wire        ext_wr,
  input  wire [15:0] dd_in,
  output reg         busy_r,
  output reg         done_r,
  output reg  [15:0] rdata_r,
  output reg         command_block_select_n_r,
  output reg         control_block_select_n_r,
  output reg  [2:0]  drive_addr_r,
  output reg         rd_pin_r,
  output reg         wr_pin_r,
  output reg  [15:0] dd_out_r,
  output reg         dd_oe_r
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_SETUP = 2'd1;
  localparam ST_STRB  = 2'd2;
  localparam ST_REC   = 2'd3;

  reg [1:0] st_r;
  reg [7:0] cnt_r;
  reg       wr_r;
  reg       rd_act;
  reg       wr_act;

  always @* begin
    rd_act = ext_rd | ((st_r == ST_STRB) & ~wr_r);
    wr_act = ext_wr | ((st_r == ST_STRB) & wr_r);
  end

  always @(posedge mclk) begin
    if (clr) begin
      st_r                     <= ST_IDLE;
      cnt_r                    <= 8'h00;
      wr_r                     <= 1'b0;
      busy_r                   <= 1'b0;
      done_r                   <= 1'b0;
      rdata_r                  <= 16'h0000;
      command_block_select_n_r <= 1'b1;
      control_block_select_n_r <= 1'b1;
      drive_addr_r             <= 3'h0;
      rd_pin_r                 <= 1'b1;
      wr_pin_r                 <= 1'b1;
      dd_out_r                 <= 16'h0000;
      dd_oe_r                  <= 1'b0;
    end else begin
      done_r   <= 1'b0;
      wr_pin_r <= wr_act ~^ wr_lvl;
      rd_pin_r <= rd_act ~^ rd_lvl;
      case (st_r)
        ST_IDLE: begin
          if (start) begin
            command_block_select_n_r <= ctl_blk;
            control_block_select_n_r <= ~ctl_blk;
            drive_addr_r             <= addr;
            wr_r                     <= wr;
            dd_out_r                 <= wdata;
            dd_oe_r                  <= wr;
            busy_r                   <= 1'b1;
            cnt_r                    <= SETUP_CYC[7:0];
            st_r                     <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (cnt_r <= 8'h01) begin
            cnt_r <= STROBE_CYC[7:0];
            st_r  <= ST_STRB;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        ST_STRB: begin
          if (cnt_r <= 8'h01) begin
            if (!wr_r) begin
              rdata_r <= dd_in;
            end
            cnt_r <= RECOVER_CYC[7:0];
            st_r  <= ST_REC;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        ST_REC: begin
          if (cnt_r <= 8'h01) begin
            command_block_select_n_r <= 1'b1;
            control_block_select_n_r <= 1'b1;
            dd_oe_r                  <= 1'b0;
            busy_r                   <= 1'b0;
            done_r                   <= 1'b1;
            st_r                     <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // dbp_pio

// [rtl/dbp_top.v]
// DMA bus hardware setting and drive task file window, AHB-Lite slave.
// Assumes single word transfers and a synchronous bus reset pulse.
//
// Notes on behaviour
// - lane field 00 normal, 01 swapped
// - swap only during slave or master DMA
// - bit5 sets end-of-transfer level, slave only
// - bit4 picks slave or master role
// - bit3 sets acknowledge level
// - bit2 sets request level
// - bit1 sets write strobe level
// - bit0 sets read strobe level
// - one byte setting, resets to 04h
// - task file access becomes drive PIO cycle
// - automatic drive selects and address lines
// - ten task file entries mapped
// - 8-bit host pairs two data accesses
// - low byte first, then high byte
// - other entries take one immediate cycle
// - data, feature, count entries reset zero
// - request pin undriven until config written
// - command entry write-only, reads FFh
`timescale 1ns/1ns
`include "dbp_consts.vh"

module dbp_top #(
  parameter SETUP_CYC   = `DBP_CYC(`DBP_T_SETUP_NS),
  parameter STROBE_CYC  = `DBP_CYC(`DBP_T_STROBE_NS),
  parameter RECOVER_CYC = `DBP_CYC(`DBP_T_RECOVER_NS)
) (
  input  wire        mclk,
  input  wire        rst_b,
  input  wire        usb_bus_rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  input  wire        dma_req_int,
  input  wire        dma_ack_int,
  input  wire        dma_rd_int,
  input  wire        dma_wr_int,
  input  wire        dma_xfer_active,
  input  wire [15:0] buf_wdata,
  input  wire [15:0] dma_pin_rdata,
  input  wire        end_of_transfer_in,
  input  wire        dma_ack_in,
  output reg         dma_req_out,
  output reg         dma_req_oe,
  output reg         dma_ack_out,
  output reg         dma_ack_oe,
  output reg         eot_seen,
  output reg         ack_seen,
  output reg  [15:0] dma_pin_wdata,
  output reg  [15:0] buf_rdata,
  output wire        command_block_select_n,
  output wire        control_block_select_n,
  output wire        drive_addr_bit2,
  output wire        drive_addr_bit1,
  output wire        drive_addr_bit0,
  output wire        read_strobe_pin,
  output wire        write_strobe_pin,
  input  wire [15:0] dd_in,
  output wire [15:0] dd_out,
  output wire        dd_oe
);

  wire clr = ~rst_b | usb_bus_rst;

  // Index to {hit, control block, drive address}
  function [4:0] tf_map;
    input [7:0] idx;
    begin
      case (idx)
        `DBP_IDX_TF_DATA:  tf_map = {2'b10, `DBP_DA_DATA};
        `DBP_IDX_TF_FEAT:  tf_map = {2'b10, `DBP_DA_FEAT};
        `DBP_IDX_TF_CNT:   tf_map = {2'b10, `DBP_DA_CNT};
        `DBP_IDX_TF_LBA0:  tf_map = {2'b10, `DBP_DA_LBA0};
        `DBP_IDX_TF_LBA1:  tf_map = {2'b10, `DBP_DA_LBA1};
        `DBP_IDX_TF_LBA2:  tf_map = {2'b10, `DBP_DA_LBA2};
        `DBP_IDX_TF_DRV:   tf_map = {2'b10, `DBP_DA_DRV};
        `DBP_IDX_TF_CMD:   tf_map = {2'b10, `DBP_DA_CMD};
        `DBP_IDX_TF_ALT:   tf_map = {2'b11, `DBP_DA_DRV};
        `DBP_IDX_TF_DADDR: tf_map = {2'b11, `DBP_DA_CMD};
        default:           tf_map = 5'h00;
      endcase
    end
  endfunction

  reg  [7:0]  hw_r;
  reg  [15:0] cfg_r;
  reg         cfg_wr_r;
  reg         host8_r;
  reg         byte_ph_r;
  reg  [7:0]  sh_lo_r;
  reg  [7:0]  sh_hi_r;
  reg  [7:0]  sh_feat_r;
  reg  [7:0]  sh_cnt_r;
  reg         ph_r;
  reg         a_wr_r;
  reg         a_ok_r;
  reg  [7:0]  a_idx_r;
  reg         wait_r;
  reg         w_data_r;
  reg         pio_go_r;
  reg         pio_wr_r;
  reg         pio_ctl_r;
  reg  [2:0]  pio_a_r;
  reg  [15:0] pio_wd_r;

  wire        pio_busy;
  wire        pio_done;
  wire [15:0] pio_rdata;
  wire [2:0]  drive_addr;

  wire        acc     = hsel & htrans[1] & hready;
  wire        addr_ok = (haddr[31:10] == 22'h000000);
  wire [7:0]  idx     = haddr[9:2];
  wire [4:0]  map_a   = tf_map(idx);
  wire [4:0]  map_d   = tf_map(a_idx_r);
  wire        is_data = (idx == `DBP_IDX_TF_DATA);
  wire        d_data  = (a_idx_r == `DBP_IDX_TF_DATA);
  wire        master  = hw_r[`DBP_HW_MASTER];
  wire        swap_on = (hw_r[`DBP_HW_LANE_HI:`DBP_HW_LANE_LO] == `DBP_LANE_SWAP)
                        & dma_xfer_active;

  wire rd_pio = addr_ok & map_a[4] & (idx != `DBP_IDX_TF_CMD)
                & ~(is_data & host8_r & byte_ph_r);
  // first data byte written is held back
  wire wr_pio = addr_ok & map_a[4] & ~(is_data & host8_r & ~byte_ph_r);

  reg [31:0] local_rd;
  always @* begin
    local_rd = 32'h00000000;
    if (addr_ok) begin
      case (idx)
        `DBP_IDX_HW_SETUP: local_rd = {24'h000000, hw_r};
        `DBP_IDX_DMA_CFG:  local_rd = {16'h0000, cfg_r};
        `DBP_IDX_HOST_CTL: local_rd = {22'h000000, byte_ph_r, pio_busy, 7'h00, host8_r};
        `DBP_IDX_TF_CMD:   local_rd = `DBP_CMD_READ;
        `DBP_IDX_TF_DATA:  local_rd = {24'h000000, sh_hi_r};
        default:           local_rd = 32'h00000000;
      endcase
    end
  end

  // Bus slave and register file
  always @(posedge mclk) begin
    if (clr) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h00000000;
      hresp     <= 1'b0;
      hw_r      <= `DBP_HW_RST;
      cfg_r     <= `DBP_CFG_RST;
      cfg_wr_r  <= 1'b0;
      host8_r   <= 1'b0;
      byte_ph_r <= 1'b0;
      sh_lo_r   <= `DBP_TF_RST;
      sh_hi_r   <= `DBP_TF_RST;
      sh_feat_r <= `DBP_TF_RST;
      sh_cnt_r  <= `DBP_TF_RST;
      ph_r      <= 1'b0;
      a_wr_r    <= 1'b0;
      a_ok_r    <= 1'b0;
      a_idx_r   <= 8'h00;
      wait_r    <= 1'b0;
      w_data_r  <= 1'b0;
      pio_go_r  <= 1'b0;
      pio_wr_r  <= 1'b0;
      pio_ctl_r <= 1'b0;
      pio_a_r   <= 3'h0;
      pio_wd_r  <= 16'h0000;
    end else begin
      hresp    <= 1'b0;
      pio_go_r <= 1'b0;
      ph_r     <= 1'b0;
      if (acc) begin
        ph_r    <= 1'b1;
        a_wr_r  <= hwrite;
        a_ok_r  <= addr_ok;
        a_idx_r <= idx;
        hrdata  <= local_rd;
        if (!hwrite && rd_pio) begin
          hreadyout <= 1'b0;
          wait_r    <= 1'b1;
          w_data_r  <= is_data;
          pio_go_r  <= 1'b1;
          pio_wr_r  <= 1'b0;
          pio_ctl_r <= map_a[3];
          pio_a_r   <= map_a[2:0];
        end else if (hwrite && wr_pio) begin
          hreadyout <= 1'b0;
          wait_r    <= 1'b1;
        end
        if (!hwrite && is_data && addr_ok && host8_r) begin
          byte_ph_r <= ~byte_ph_r;
        end
      end
      if (ph_r && a_wr_r && a_ok_r) begin
        case (a_idx_r)
          `DBP_IDX_HW_SETUP: hw_r <= hwdata[7:0];
          `DBP_IDX_DMA_CFG: begin
            cfg_r    <= hwdata[15:0] & `DBP_CFG_MASK;
            cfg_wr_r <= 1'b1;
          end
          `DBP_IDX_HOST_CTL: host8_r <= hwdata[`DBP_CTL_HOST8];
          `DBP_IDX_TF_FEAT:  sh_feat_r <= hwdata[7:0];
          `DBP_IDX_TF_CNT:   sh_cnt_r <= hwdata[7:0];
          default: begin
          end
        endcase
        if (d_data && host8_r) begin
          byte_ph_r <= ~byte_ph_r;
          if (!byte_ph_r) begin
            sh_lo_r <= hwdata[7:0];
          end else begin
            sh_hi_r <= hwdata[7:0];
          end
        end
        if (map_d[4] && wait_r) begin
          pio_go_r  <= 1'b1;
          pio_wr_r  <= 1'b1;
          pio_ctl_r <= map_d[3];
          pio_a_r   <= map_d[2:0];
          pio_wd_r  <= (d_data && host8_r) ? {hwdata[7:0], sh_lo_r} : hwdata[15:0];
        end
      end
      if (pio_done && wait_r) begin
        hreadyout <= 1'b1;
        wait_r    <= 1'b0;
        if (!pio_wr_r) begin
          if (w_data_r) begin
            sh_lo_r <= pio_rdata[7:0];
            sh_hi_r <= pio_rdata[15:8];
            hrdata  <= host8_r ? {24'h000000, pio_rdata[7:0]}
                               : {16'h0000, pio_rdata};
          end else begin
            hrdata <= {24'h000000, pio_rdata[7:0]};
            if (pio_a_r == `DBP_DA_FEAT && !pio_ctl_r) begin
              sh_feat_r <= pio_rdata[7:0];
            end
            if (pio_a_r == `DBP_DA_CNT && !pio_ctl_r) begin
              sh_cnt_r <= pio_rdata[7:0];
            end
          end
        end
      end
    end
  end

  // DMA pins and lane swap
  always @(posedge mclk) begin
    if (clr) begin
      dma_req_out   <= 1'b1;
      dma_req_oe    <= 1'b0;
      dma_ack_out   <= 1'b1;
      dma_ack_oe    <= 1'b0;
      eot_seen      <= 1'b0;
      ack_seen      <= 1'b0;
      dma_pin_wdata <= 16'h0000;
      buf_rdata     <= 16'h0000;
    end else begin
      dma_req_out <= dma_req_int ~^ hw_r[`DBP_HW_REQ_LVL];
      dma_req_oe  <= cfg_wr_r;
      dma_ack_out <= dma_ack_int ~^ hw_r[`DBP_HW_ACK_LVL];
      dma_ack_oe  <= master;
      ack_seen    <= ~master & (dma_ack_in ~^ hw_r[`DBP_HW_ACK_LVL]);
      // end of transfer in slave mode
      eot_seen    <= ~master & (end_of_transfer_in ~^ hw_r[`DBP_HW_EOT_LVL]);
      dma_pin_wdata <= swap_on ? {buf_wdata[7:0], buf_wdata[15:8]} : buf_wdata;
      buf_rdata     <= swap_on ? {dma_pin_rdata[7:0], dma_pin_rdata[15:8]}
                               : dma_pin_rdata;
    end
  end

  dbp_pio #(
    .SETUP_CYC   (SETUP_CYC),
    .STROBE_CYC  (STROBE_CYC),
    .RECOVER_CYC (RECOVER_CYC)
  ) u_pio (
    .mclk                     (mclk),
    .clr                      (clr),
    .start                    (pio_go_r),
    .wr                       (pio_wr_r),
    .ctl_blk                  (pio_ctl_r),
    .addr                     (pio_a_r),
    .wdata                    (pio_wd_r),
    .rd_lvl                   (hw_r[`DBP_HW_RD_LVL]),
    .wr_lvl                   (hw_r[`DBP_HW_WR_LVL]),
    .ext_rd                   (master & dma_rd_int),
    .ext_wr                   (master & dma_wr_int),
    .dd_in                    (dd_in),
    .busy_r                   (pio_busy),
    .done_r                   (pio_done),
    .rdata_r                  (pio_rdata),
    .command_block_select_n_r (command_block_select_n),
    .control_block_select_n_r (control_block_select_n),
    .drive_addr_r             (drive_addr),
    .rd_pin_r                 (read_strobe_pin),
    .wr_pin_r                 (write_strobe_pin),
    .dd_out_r                 (dd_out),
    .dd_oe_r                  (dd_oe)
  );

  assign drive_addr_bit2 = drive_addr[2];
  assign drive_addr_bit1 = drive_addr[1];
  assign drive_addr_bit0 = drive_addr[0];

endmodule // dbp_top

// [testbench/dbp_top_asserts.sv]
// Checker of the setting byte pins and the drive window handshake.
// Assumes hready is fed back from hreadyout by the bench.
`timescale 1ns/1ns
module dbp_top_asserts #(
  parameter SETUP_CYC   = 7,
  parameter STROBE_CYC  = 17,
  parameter RECOVER_CYC = 3
) (
  input wire        mclk,
  input wire        rst_b,
  input wire        usb_bus_rst,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire        dma_req_int,
  input wire        dma_ack_int,
  input wire        dma_xfer_active,
  input wire [15:0] buf_wdata,
  input wire [15:0] dma_pin_rdata,
  input wire        end_of_transfer_in,
  input wire        dma_ack_in,
  input wire        dma_req_out,
  input wire        dma_req_oe,
  input wire        dma_ack_out,
  input wire        dma_ack_oe,
  input wire        eot_seen,
  input wire        ack_seen,
  input wire [15:0] dma_pin_wdata,
  input wire [15:0] buf_rdata,
  input wire        command_block_select_n,
  input wire        control_block_select_n,
  input wire        read_strobe_pin,
  input wire        write_strobe_pin,
  input wire        dd_oe
);
  localparam int WAIT_MAX = SETUP_CYC + STROBE_CYC + RECOVER_CYC + 8;
  wire        clr = !rst_b || usb_bus_rst;
  reg         ph_wr_r;
  reg  [31:0] ph_addr_r;
  reg  [7:0]  hw_r;
  reg         cfg_r;
  reg  [15:0] bw_r;
  reg  [15:0] pr_r;
  reg  [4:0]  in_r;
  wire        swp = in_r[4] && hw_r[7:6] == 2'h1;
  wire        any_sel = !command_block_select_n || !control_block_select_n;

  // Shadow of the setting byte and inputs of the last edge
  always @(posedge mclk) begin
    bw_r <= buf_wdata;
    pr_r <= dma_pin_rdata;
    in_r <= {dma_xfer_active, dma_req_int, dma_ack_int, end_of_transfer_in, dma_ack_in};
    if (clr) begin
      ph_wr_r <= 1'b0;
      hw_r    <= 8'h04;
      cfg_r   <= 1'b0;
    end else if (hready) begin
      ph_wr_r   <= hsel && htrans[1] && hwrite;
      ph_addr_r <= haddr;
      if (ph_wr_r && ph_addr_r == 32'hF0) hw_r <= hwdata[7:0];
      if (ph_wr_r && ph_addr_r == 32'hE0) cfg_r <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (clr);

  sequence settled;
    $stable(hw_r) && !$past(clr);
  endsequence

  pin_levels_a: assert property (
    settled |-> dma_req_out == (in_r[3] ~^ hw_r[2]) && dma_ack_out == (in_r[2] ~^ hw_r[3]))
    else $error("request or acknowledge level wrong");
  slave_inputs_a: assert property (
    settled |-> eot_seen == (!hw_r[4] && (in_r[1] ~^ hw_r[5]))
      && ack_seen == (!hw_r[4] && (in_r[0] ~^ hw_r[3])))
    else $error("sampled input level wrong");
  role_sel_a: assert property (settled |-> dma_ack_oe == hw_r[4])
    else $error("acknowledge drive does not follow role");
  swap_a: assert property (
    settled |-> dma_pin_wdata == (swp ? {bw_r[7:0], bw_r[15:8]} : bw_r)
      && buf_rdata == (swp ? {pr_r[7:0], pr_r[15:8]} : pr_r))
    else $error("lane order wrong");
  strobe_sel_a: assert property (
    settled and (!hw_r[4] && ((read_strobe_pin ~^ hw_r[0]) || (write_strobe_pin ~^ hw_r[1])))
      |-> any_sel)
    else $error("strobe active without a select");
  sel_excl_a: assert property (!(!command_block_select_n && !control_block_select_n))
    else $error("both drive selects low");
  drive_out_a: assert property (dd_oe |-> any_sel)
    else $error("drive data driven without a select");
  req_hold_a: assert property (!cfg_r |-> !dma_req_oe)
    else $error("request pin driven before config write");
  wait_bound_a: assert property ($fell(hreadyout) |-> ##[1:WAIT_MAX] hreadyout)
    else $error("drive cycle wait too long");
  okay_resp_a: assert property (!hresp)
    else $error("bus response not OKAY");

  hw_write_c: cover property (ph_wr_r && ph_addr_r == 32'hF0 && hready);
  swap_c: cover property (swp);
  pio_c: cover property ($fell(hreadyout));
endmodule // dbp_top_asserts

// [testbench/dbp_drive_model.sv]
// Drive model: task file registers behind the select and strobe pins.
// Assumes the bench passes the strobe levels of the setting byte.
`timescale 1ns/1ns
module dbp_drive_model (
  input  wire        mclk,
  input  wire        command_block_select_n,
  input  wire        control_block_select_n,
  input  wire [2:0]  drive_addr,
  input  wire        read_strobe_pin,
  input  wire        write_strobe_pin,
  input  wire [1:0]  strobe_lvl,
  input  wire [15:0] dd_out,
  input  wire        dd_oe,
  output wire [15:0] dd_in
);
  reg  [15:0] mem [0:15];
  reg  [15:0] last_r;
  reg         wr_q_r;
  reg         rd_q_r;
  integer     wr_count = 0;
  integer     rd_count = 0;
  wire        sel = !command_block_select_n || !control_block_select_n;
  wire        rd_act = (read_strobe_pin ~^ strobe_lvl[0]) && sel;
  wire        wr_act = (write_strobe_pin ~^ strobe_lvl[1]) && sel;
  wire [3:0]  idx = {!control_block_select_n, drive_addr};
  // Released data lines show the inverse of the last value
  assign dd_in = rd_act ? mem[idx] : ~last_r;

  initial begin
    last_r = 16'h0000;
    for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
  end

  always @(posedge mclk) begin
    wr_q_r <= wr_act;
    rd_q_r <= rd_act;
    if (rd_act) last_r <= mem[idx];
    if (wr_act) mem[idx] <= dd_oe ? dd_out : ~dd_out;
    if (wr_act && !wr_q_r) wr_count <= wr_count + 1;
    if (rd_act && !rd_q_r) rd_count <= rd_count + 1;
  end
endmodule // dbp_drive_model

// [testbench/dbp_top_bench.sv]
// Bench for the setting byte and the drive task file window.
// Assumes the drive model answers every programmed I/O cycle.
`timescale 1ns/1ns
module dbp_top_bench;
  logic        mclk = 0;
  logic        rst_b = 0;
  logic        usb_bus_rst = 0;
  logic        hsel = 0;
  logic [31:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic        hwrite = 0;
  logic [31:0] hwdata = 0;
  logic [36:0] rin = 0;
  logic [1:0]  lvl = 0, mstb = 0;
  logic [31:0] rdat, d, mask;
  logic [7:0]  hw, lo, hi;
  int          errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          n;
  wire         hreadyout, cs_n, ctl_n, da2, da1, da0, rd_pin, wr_pin, dd_oe;
  wire         req_oe, ack_oe;
  wire [31:0]  hrdata;
  wire [15:0]  dd_in, dd_out;

  dbp_top #(.SETUP_CYC(2), .STROBE_CYC(3), .RECOVER_CYC(1)) u_dbp_top (
    .mclk(mclk), .rst_b(rst_b), .usb_bus_rst(usb_bus_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .dma_req_int(rin[0]),
    .dma_ack_int(rin[1]), .dma_rd_int(mstb[0]), .dma_wr_int(mstb[1]), .dma_xfer_active(rin[2]),
    .buf_wdata(rin[20:5]), .dma_pin_rdata(rin[36:21]), .end_of_transfer_in(rin[3]),
    .dma_ack_in(rin[4]), .dma_req_out(), .dma_req_oe(req_oe), .dma_ack_out(),
    .dma_ack_oe(ack_oe), .eot_seen(), .ack_seen(), .dma_pin_wdata(), .buf_rdata(),
    .command_block_select_n(cs_n), .control_block_select_n(ctl_n), .drive_addr_bit2(da2),
    .drive_addr_bit1(da1), .drive_addr_bit0(da0), .read_strobe_pin(rd_pin),
    .write_strobe_pin(wr_pin), .dd_in(dd_in), .dd_out(dd_out), .dd_oe(dd_oe));

  dbp_drive_model u_dbp_drive_model (.mclk(mclk), .command_block_select_n(cs_n),
    .control_block_select_n(ctl_n), .drive_addr({da2, da1, da0}), .read_strobe_pin(rd_pin),
    .write_strobe_pin(wr_pin), .strobe_lvl(lvl), .dd_out(dd_out), .dd_oe(dd_oe),
    .dd_in(dd_in));

  always #5 mclk = ~mclk;

  // Random side inputs and the run limit
  always @(posedge mclk) begin
    rin <= 37'({$urandom, $urandom});
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Byte address and drive code of the nine read/write entries
  function automatic logic [31:0] tf_addr(input int i);
    return (i == 0) ? 32'h100 : 32'h11C + 4 * i;
  endfunction
  function automatic logic [3:0] tf_code(input int i);
    return (i < 7) ? 4'(i) : 4'(i + 7);
  endfunction

  initial begin
    rdat = $urandom(32'h8002);
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    bus(0, 32'hF0, 0);
    chk("setting reset", 32'h04, rdat);
    chk("request enable", 0, req_oe);
    bus(0, 32'h1F0, 0);
    chk("unmapped read", 0, rdat);
    // 16-bit width keeps any lane value legal
    bus(1, 32'hE0, 32'h0001);
    repeat (2) @(posedge mclk);
    chk("request enable on", 1, req_oe);
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      hw = $urandom;
      bus(1, 32'hF0, hw);
      lvl = hw[1:0];
      bus(0, 32'hF0, 0);
      chk("setting", hw, rdat);
      chk("role", hw[4], ack_oe);
      chk("strobe idle", 2'(~hw[1:0]), {wr_pin, rd_pin});
      mask = (i == 0) ? 32'hFFFF : 32'hFF;
      d = $urandom & mask;
      n = u_dbp_drive_model.wr_count;
      bus(1, tf_addr(i), d);
      chk("drive reg", d, u_dbp_drive_model.mem[tf_code(i)] & mask);
      chk("write cycles", n + 1, u_dbp_drive_model.wr_count);
      bus(0, tf_addr(i), 0);
      chk("entry read", d, rdat & mask);
    end
    $display("test window done");
    d = $urandom & 32'hFF;
    n = u_dbp_drive_model.rd_count;
    bus(1, 32'h110, d);
    chk("command reg", d, u_dbp_drive_model.mem[7] & 32'hFF);
    bus(0, 32'h110, 0);
    chk("command read", 32'hFF, rdat);
    chk("command no read", n, u_dbp_drive_model.rd_count);
    $display("test command done");
    bus(1, 32'h180, 1);
    lo = $urandom;
    hi = $urandom;
    n = u_dbp_drive_model.wr_count;
    bus(1, 32'h100, lo);
    chk("first byte held", n, u_dbp_drive_model.wr_count);
    bus(1, 32'h100, hi);
    chk("paired word", {hi, lo}, u_dbp_drive_model.mem[0]);
    chk("paired count", n + 1, u_dbp_drive_model.wr_count);
    n = u_dbp_drive_model.rd_count;
    bus(0, 32'h100, 0);
    chk("low byte", lo, rdat[7:0]);
    bus(0, 32'h100, 0);
    chk("high byte", hi, rdat[7:0]);
    chk("read count", n + 1, u_dbp_drive_model.rd_count);
    bus(1, 32'h180, 0);
    bus(1, 32'hF0, 32'h10);
    mstb <= 2'h1;
    repeat (3) @(posedge mclk);
    chk("master strobe", 2'h2, {wr_pin, rd_pin});
    mstb <= 2'h0;
    $display("test pairing done");
    usb_bus_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    usb_bus_rst <= 1'b0;
    lvl = 2'h0;
    @(posedge mclk);
    bus(0, 32'hF0, 0);
    chk("setting bus reset", 32'h04, rdat);
    chk("request off", 0, req_oe);
    chk("strobes idle", 2'h3, {wr_pin, rd_pin});
    $display("test bus reset done");
    end_sim();
  end
endmodule // dbp_top_bench

bind dbp_top dbp_top_asserts #(.SETUP_CYC(SETUP_CYC), .STROBE_CYC(STROBE_CYC),
  .RECOVER_CYC(RECOVER_CYC)) u_dbp_top_asserts (.mclk, .rst_b, .usb_bus_rst, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .dma_req_int, .dma_ack_int,
  .dma_xfer_active, .buf_wdata, .dma_pin_rdata, .end_of_transfer_in, .dma_ack_in,
  .dma_req_out, .dma_req_oe, .dma_ack_out, .dma_ack_oe, .eot_seen, .ack_seen,
  .dma_pin_wdata, .buf_rdata, .command_block_select_n, .control_block_select_n,
  .read_strobe_pin, .write_strobe_pin, .dd_oe);
